// file: verilog/reset_cause_status.sv
// reset-cause status register with AXI4-Lite slave and interrupt
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module reset_cause_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire reset_cause_pkg::reset_events_t events,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // the block only records causes; it never starts a reset itself. flags
  // are set by one-cycle or level strobes on the events bundle and cleared
  // by software over the register bus. the status word is deliberately not
  // wiped by aresetn, because its whole purpose is to survive the reset it
  // describes. irq_status is a separate sticky copy for the interrupt, so
  // acknowledging the interrupt never destroys the cause record.
  // limitation: only one write and one read are accepted at a time; the
  // bus is a status port, not a data path, so throughput was not a goal.

  // ==========================================================
  // event vector
  logic [31:0] hw_set;
  logic [31:0] status;
  logic [31:0] irq_status;
  logic [31:0] irq_enable;
  logic [31:0] next_status;
  logic [31:0] next_irq_status;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic [31:0] byte_mask;
  logic [31:0] wr_bits;
  // write address decode, one line per writable location
  logic hit_status;
  logic hit_clear;
  logic hit_set;
  logic hit_invert;
  logic hit_irq_clear;
  logic hit_irq_enable;
  logic aw_known;
  // read side
  logic rd_take;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // each event line maps onto one flag, sleep_wake onto two; a line held high for several
  // cycles simply keeps setting the same flag
  always_comb begin
    hw_set = '0;
    hw_set[reset_cause_pkg::supply_power_on_bit] = events.supply_power_on;
    hw_set[reset_cause_pkg::core_power_on_bit] = events.core_power_on;
    hw_set[reset_cause_pkg::primary_cfg_err_bit] = events.primary_cfg_err;
    hw_set[reset_cause_pkg::both_cfg_fail_bit] = events.both_cfg_fail;
    hw_set[reset_cause_pkg::cfg_mismatch_bit] = events.cfg_mismatch;
    hw_set[reset_cause_pkg::ext_pin_bit] = events.ext_pin;
    hw_set[reset_cause_pkg::software_bit] = events.software;
    hw_set[reset_cause_pkg::watchdog_bit] = events.watchdog;
    hw_set[reset_cause_pkg::sleep_wake_bit] = events.sleep_wake;
    // waking from sleep also passes through idle
    hw_set[reset_cause_pkg::idle_wake_bit] = events.idle_wake | events.sleep_wake;
    hw_set[reset_cause_pkg::brownout_bit] = events.brownout;
    hw_set[reset_cause_pkg::power_on_bit] = events.power_on;
  end

  // ==========================================================
  // write channel capture
  // address and data are latched independently and may arrive in either
  // order; the write is applied once both are held and no answer is pending
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // awready is a one-cycle pulse raised only while no address is held, so a
  // second address simply waits until the current write has been applied
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !aw_held && !s_axi_awready && !do_write;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  // data side mirrors the address side; the strobes travel with the data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= s_axi_wvalid && !w_held && !s_axi_wready && !do_write;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  // the answer is raised on the edge that applies the write, so a read
  // issued after the response always sees the new register contents

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= reset_cause_pkg::resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      // an unmapped or read-only location is answered but changes nothing
      s_axi_bresp <= aw_known ? reset_cause_pkg::resp_okay : reset_cause_pkg::resp_slverr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{w_strb[i]}};
    end
    wr_bits = w_data & byte_mask;
  end

  // ==========================================================
  // write decode on the held address; the strobes are qualified by
  // do_write where they are used, so a stale address does nothing
  always_comb begin
    hit_status = aw_addr == reset_cause_pkg::status_addr;
    hit_clear = aw_addr == reset_cause_pkg::clear_addr;
    hit_set = aw_addr == reset_cause_pkg::set_addr;
    hit_invert = aw_addr == reset_cause_pkg::invert_addr;
    hit_irq_clear = aw_addr == reset_cause_pkg::irq_clear_addr;
    hit_irq_enable = aw_addr == reset_cause_pkg::irq_enable_addr;
    // irq_status is read-only, so a write there falls through to an error
    aw_known = hit_status | hit_clear | hit_set | hit_invert | hit_irq_clear | hit_irq_enable;
  end

  // ==========================================================
  // status flags: software edits first, hardware sets applied last
  always_comb begin
    next_status = status;
    // the clear, set and invert aliases let software change single flags
    // without a read-modify-write that could race a hardware set
    // only one strobe can be high, the held address selects at most one
    if (do_write && hit_status) begin
      next_status = (status & ~byte_mask) | wr_bits;
    end
    if (do_write && hit_clear) begin
      next_status = status & ~wr_bits;
    end
    if (do_write && hit_set) begin
      next_status = status | wr_bits;
    end
    if (do_write && hit_invert) begin
      next_status = status ^ wr_bits;
    end
    // set after the software edit so an event is never lost
    next_status = (next_status | hw_set) & reset_cause_pkg::implemented_mask;
  end

  // the reset branch folds in the reset-cause pattern instead of clearing,
  // so software can still read why the last reset happened; a cause that
  // arrives while reset is held is merged in as well. a flag set by neither
  // stays at its unknown power-up value through every reset, so the first
  // software action should be a write of the whole word.
  // aresetn is the ordinary system reset; flags are only lost on a real power-up of this logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= (status | hw_set | reset_cause_pkg::status_reset)
        & reset_cause_pkg::implemented_mask;
    end else begin
      status <= next_status;
    end
  end

  // ==========================================================
  // interrupt: sticky event bits, write-one-to-clear, enable mask
  // irq_status mirrors the flag layout but is cleared on its own, so a
  // handler can acknowledge the interrupt and still find the cause later
  always_comb begin
    next_irq_status = irq_status;
    if (do_write && hit_irq_clear) begin
      next_irq_status = irq_status & ~wr_bits;
    end
    next_irq_status = (next_irq_status | hw_set) & reset_cause_pkg::implemented_mask;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= reset_cause_pkg::irq_enable_reset;
    end else if (do_write && hit_irq_enable) begin
      irq_enable <= ((irq_enable & ~byte_mask) | wr_bits) & reset_cause_pkg::implemented_mask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      // taken from the next value so irq rises on the same edge as the flag;
      // a change of enable shows one cycle after the write is applied
      irq <= |(next_irq_status & irq_enable);
    end
  end

  // ==========================================================
  // read channel: one cycle ready, data the cycle after
  // a read has no side effect on any flag, so software may poll the
  // status word freely; clearing is always an explicit write
  // address phase taken when arvalid meets the one-cycle arready pulse
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // write-only locations answer zero with an okay response
  always_comb begin
    next_rdata = '0;
    next_rresp = reset_cause_pkg::resp_okay;
    unique case (s_axi_araddr)
      reset_cause_pkg::status_addr: next_rdata = status;
      reset_cause_pkg::irq_status_addr: next_rdata = irq_status;
      reset_cause_pkg::irq_enable_addr: next_rdata = irq_enable;
      reset_cause_pkg::clear_addr,
      reset_cause_pkg::set_addr,
      reset_cause_pkg::invert_addr,
      reset_cause_pkg::irq_clear_addr: next_rdata = '0;
      default: next_rresp = reset_cause_pkg::resp_slverr;
    endcase
  end

  // arready pulses once per request and never while an answer is pending,
  // which keeps at most one read in flight without any queue
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    end
  end

  // rvalid stands until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // data and response are captured only on the taking edge, so they stand
  // unchanged for as long as the master stalls rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= reset_cause_pkg::resp_okay;
    end else if (rd_take) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule : reset_cause_status
`default_nettype wire

// file: include/reset_cause_pkg.sv
// package: register map, field positions and reset values of the reset-cause status block
package reset_cause_pkg;
  // register byte addresses
  localparam logic [7:0] status_addr = 8'h00;
  localparam logic [7:0] clear_addr = 8'h04;
  localparam logic [7:0] set_addr = 8'h08;
  localparam logic [7:0] invert_addr = 8'h0C;
  localparam logic [7:0] irq_status_addr = 8'h10;
  localparam logic [7:0] irq_clear_addr = 8'h14;
  localparam logic [7:0] irq_enable_addr = 8'h18;

  // field positions
  localparam int supply_power_on_bit = 31;
  localparam int core_power_on_bit = 30;
  localparam int primary_cfg_err_bit = 27;
  localparam int both_cfg_fail_bit = 26;
  localparam int cfg_mismatch_bit = 9;
  localparam int ext_pin_bit = 7;
  localparam int software_bit = 6;
  localparam int watchdog_bit = 4;
  localparam int sleep_wake_bit = 3;
  localparam int idle_wake_bit = 2;
  localparam int brownout_bit = 1;
  localparam int power_on_bit = 0;

  // implemented bits; all others read as zero
  localparam logic [31:0] implemented_mask = 32'hCC0002DF;
  // pattern folded in on every aresetn reset: both power-on flags, brown-out and power-on set
  localparam logic [31:0] status_reset = 32'hC0000003;
  localparam logic [31:0] irq_enable_reset = 32'h00000000;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // hardware event strobes, one cycle or held high for several
  typedef struct packed {
    logic supply_power_on;
    logic core_power_on;
    logic primary_cfg_err;
    logic both_cfg_fail;
    logic cfg_mismatch;
    logic ext_pin;
    logic software;
    logic watchdog;
    logic sleep_wake;
    logic idle_wake;
    logic brownout;
    logic power_on;
  } reset_events_t;
endpackage : reset_cause_pkg

// file: verification/reset_cause_checker.sv
// assertion checker for the reset-cause status block
`timescale 1ns/10ps
`default_nettype none
module reset_cause_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // bus timing and register content
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_ar_to_r: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_aw_to_b: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready not a pulse");
  a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready not a pulse");
  a_rdata_masked: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'h33FFFD20) == '0)
    else $error("unimplemented bit read as one");
  // irq can only fall on a register write, never by itself
  a_irq_sticky: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("irq fell without a write");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : reset_cause_checker
bind reset_cause_status reset_cause_checker i_chk (.*);
`default_nettype wire

// file: verification/reset_cause_status_tb.sv
// self-checking testbench for the reset-cause status block
`timescale 1ns/10ps
`default_nettype none
module reset_cause_status_tb;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, m_st, m_iq, r, c;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  reset_cause_pkg::reset_events_t events = '0;
  int miscompares = 0, n_compared = 0;
  localparam logic [7:0] a_st = 8'h00, a_clr = 8'h04, a_set = 8'h08, a_iq = 8'h10;
  localparam logic [7:0] a_iqc = 8'h14, a_ien = 8'h18;
  localparam logic [1:0] ok = 2'h0, err = 2'h2;
  // flag mask for each event line, lsb first; sleep wake also sets the idle flag
  logic [31:0] ev_mask [12] = '{32'h1, 32'h2, 32'h4, 32'hC, 32'h10, 32'h40, 32'h80,
    32'h200, 32'h4000000, 32'h8000000, 32'h40000000, 32'h80000000};
  reset_cause_status i_reset_cause_status (.*);
  initial forever #2 aclk = ~aclk;
  // ==========
  // checking and bus tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("miscompares %0d n_compared %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // ready is raised only after valid is seen, so the answer must stand a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      if (!s_axi_bready) s_axi_bready <= s_axi_bvalid;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= '0;
    chk(32'(s_axi_bresp), 32'(e));
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
      if (!s_axi_rready) s_axi_rready <= s_axi_rvalid;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= '0;
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(e));
    @(posedge aclk);
  endtask : rd
  task automatic pulse(input logic [11:0] e);
    events <= reset_cause_pkg::reset_events_t'(e);
    @(posedge aclk);
    events <= '0;
    @(posedge aclk);
  endtask : pulse
  function automatic logic [31:0] mk(input logic [11:0] e);
    logic [31:0] m = '0;
    for (int i = 0; i < 12; i++) if (e[i]) m |= ev_mask[i];
    return m;
  endfunction : mk
  // ==========
  // main sequence
  initial begin
    void'($urandom(59408));
    repeat (20) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    wr(a_st, '0, ok);
    pulse(12'h010);
    aresetn <= '0;
    repeat (2) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    rd(a_st, 32'hC0000013, ok);
    wr(a_clr, '1, ok);
    for (int i = 0; i < 12; i++) begin
      pulse(12'(1 << i));
      rd(a_st, ev_mask[i], ok);
      wr(a_clr, ev_mask[i], ok);
      rd(a_st, '0, ok);
    end
    m_iq = 32'hCC0002DF;
    m_st = '0;
    repeat (24) begin
      r = $urandom;
      c = {r[15:0], r[31:16]};
      pulse(r[11:0]);
      m_st = (m_st | mk(r[11:0])) & ~c;
      m_iq = (m_iq | mk(r[11:0])) & ~c;
      wr(a_ien, r, ok);
      wr(a_iqc, c, ok);
      wr(a_clr, c, ok);
      chk(32'(irq), 32'(|(m_iq & r)));
      rd(a_st, m_st, ok);
      rd(a_iq, m_iq, ok);
      rd(a_ien, r & 32'hCC0002DF, ok);
    end
    // event lands on the very edge where the clear is applied
    fork
      wr(a_clr, 32'h40, ok);
      begin
        @(posedge aclk iff s_axi_awready);
        events <= reset_cause_pkg::reset_events_t'(12'h020);
        @(posedge aclk);
        events <= '0;
      end
    join
    rd(a_st, m_st | 32'h40, ok);
    wr(a_set, '1, ok);
    rd(a_st, 32'hCC0002DF, ok);
    wr(8'h0C, 32'h80000001, ok);
    rd(a_st, 32'h4C0002DE, ok);
    s_axi_wstrb <= 4'h1;
    wr(a_clr, '1, ok);
    s_axi_wstrb <= 4'hF;
    rd(a_st, 32'h4C000200, ok);
    rd(a_clr, '0, ok);
    wr(8'h1C, '1, err);
    rd(8'h1C, '0, err);
    end_sim;
  end
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
endmodule : reset_cause_status_tb
`default_nettype wire
